// file: design/mdio_cmd_done_irq_mask.sv
// Command-done interrupt masking for the two user PHY access slots
//
// Notes on behaviour
// - Masked bit needs completion and enable set
// - Bit 0 first slot, bit 1 second
// - Writing one clears pending; zero ignored
// - Enable-set write one enables; zero ignored
// - Enable zero keeps masked bit low
// - Enable-clear write one disables; zero ignored
// - Set and clear share one enable vector
// - Raw flag set on slot completion
`timescale 1ns/1ps
`default_nettype none
`include "cmd_done_irq_params.svh"

module mdio_cmd_done_irq_mask #(
    parameter int NUM_SLOTS = `SLOT_COUNT,  // Access slots
    parameter int ADDR_W = 8                // Register address width
) (
    input wire logic ref_clk,                                  // 125 MHz clock
    input wire logic rst,                                      // Async reset, high
    input wire logic clkEn,                                    // Clock enable
    input wire logic [ADDR_W-1:0] regAddr,                     // Byte address
    input wire logic [31:0] regWrData,                         // Write data
    input wire logic regWr,                                    // Write strobe
    input wire logic regRd,                                    // Read strobe
    output var cmd_done_irq_pkg::bus_word_t regRdData,         // Read data
    output logic regRdValid,                                   // Read data valid
    input wire logic [NUM_SLOTS-1:0] slotDone,                 // Slot finished
    output logic [NUM_SLOTS-1:0] enableVec,                    // Enable vector
    output logic userCmdIrq                                    // Interrupt request
);

    logic [NUM_SLOTS-1:0] rawVec;
    logic [NUM_SLOTS-1:0] maskedVec;
    logic [NUM_SLOTS-1:0] wrBits;
    logic [NUM_SLOTS-1:0] clrRawVec;
    logic [NUM_SLOTS-1:0] setEnVec;
    logic [NUM_SLOTS-1:0] clrEnVec;
    cmd_done_irq_pkg::reg_sel_t sel;
    cmd_done_irq_pkg::bus_word_t next_rdData;

    // Slot field of the write data; upper bits are reserved
    assign wrBits = regWrData[NUM_SLOTS-1:0];

    // Address decode; unmapped addresses select nothing
    always_comb begin
        case (regAddr)
            `OFS_RAW_STATUS: sel = cmd_done_irq_pkg::SEL_RAW;
            `OFS_MASKED_STATUS: sel = cmd_done_irq_pkg::SEL_MASKED;
            `OFS_ENABLE_SET: sel = cmd_done_irq_pkg::SEL_SET;
            `OFS_ENABLE_CLEAR: sel = cmd_done_irq_pkg::SEL_CLEAR;
            default: sel = cmd_done_irq_pkg::SEL_NONE;
        endcase
    end

    // Write-one strobes per slot
    always_comb begin
        clrRawVec = '0;
        setEnVec = '0;
        clrEnVec = '0;
        if (regWr) begin
            case (sel)
                cmd_done_irq_pkg::SEL_RAW: clrRawVec = wrBits;
                cmd_done_irq_pkg::SEL_MASKED: clrRawVec = wrBits;
                cmd_done_irq_pkg::SEL_SET: setEnVec = wrBits;
                cmd_done_irq_pkg::SEL_CLEAR: clrEnVec = wrBits;
                default: clrRawVec = '0;
            endcase
        end
    end

    // One flag and enable per slot, bit index equals slot number
    generate
        for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
            slot_ctl_if slotBus ();

            assign slotBus.done = slotDone[i];
            assign slotBus.clrRaw = clrRawVec[i];
            assign slotBus.setEn = setEnVec[i];
            assign slotBus.clrEn = clrEnVec[i];
            assign rawVec[i] = slotBus.raw;
            assign enableVec[i] = slotBus.en;
            assign maskedVec[i] = slotBus.masked;

            slot_flag u_flag (
                .ref_clk(ref_clk),
                .rst(rst),
                .clkEn(clkEn),
                .bus(slotBus.flag)
            );
        end
    endgenerate

    // Read mux; enable reads back the same at set and clear offsets
    always_comb begin
        next_rdData = `READ_DATA_RESET;
        case (sel)
            cmd_done_irq_pkg::SEL_RAW: next_rdData[NUM_SLOTS-1:0] = rawVec;
            cmd_done_irq_pkg::SEL_MASKED: next_rdData[NUM_SLOTS-1:0] = maskedVec;
            cmd_done_irq_pkg::SEL_SET: next_rdData[NUM_SLOTS-1:0] = enableVec;
            cmd_done_irq_pkg::SEL_CLEAR: next_rdData[NUM_SLOTS-1:0] = enableVec;
            default: next_rdData = `READ_DATA_RESET;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            regRdData <= `READ_DATA_RESET;
            regRdValid <= 1'h0;
        end else if (clkEn) begin
            regRdValid <= regRd;
            regRdData <= regRd ? next_rdData : `READ_DATA_RESET;
        end
    end

    // Level request; combinational so a clear drops it at once
    assign userCmdIrq = |maskedVec;

    // Checks; all share the one clock and reset
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Masked bit rises only from completion or enable
    property p_masked_cause;
        $rose(maskedVec[0]) |->
            ($past(slotDone[0]) && enableVec[0]) ||
            ($past(setEnVec[0]) && rawVec[0]);
    endproperty
    a_masked_cause: assert property (p_masked_cause)
        else $error("masked bit 0 rose without cause");

    // Slot 1 maps to bit 1 of the masked read
    property p_bit_map;
        (clkEn && regRd && regAddr == `OFS_MASKED_STATUS) |=>
            regRdData == {30'h0, $past(maskedVec)};
    endproperty
    a_bit_map: assert property (p_bit_map)
        else $error("masked status read mismatch");

    // Writing one to masked status clears the pending flag
    property p_w1c_clear;
        (clkEn && regWr && regAddr == `OFS_MASKED_STATUS
            && regWrData[1] && !slotDone[1]) |=> !rawVec[1];
    endproperty
    a_w1c_clear: assert property (p_w1c_clear)
        else $error("write one did not clear slot 1");

    // Writing zero leaves a pending flag standing
    property p_w0_keep;
        (clkEn && regWr && regAddr == `OFS_MASKED_STATUS
            && !regWrData[0] && rawVec[0]) |=> rawVec[0];
    endproperty
    a_w0_keep: assert property (p_w0_keep)
        else $error("write zero cleared slot 0");

    // Completion in the clearing cycle is kept
    property p_set_wins;
        (clkEn && slotDone[0] && clrRawVec[0]) |=> rawVec[0];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("completion lost to clear");

    // Enable-set write of one enables the slot
    property p_en_set;
        (clkEn && regWr && regAddr == `OFS_ENABLE_SET && regWrData[0])
            |=> enableVec[0];
    endproperty
    a_en_set: assert property (p_en_set)
        else $error("enable set failed");

    // Enable-set write of zeros changes nothing
    property p_en_set_zero;
        (clkEn && regWr && regAddr == `OFS_ENABLE_SET
            && regWrData[1:0] == 2'h0) |=> $stable(enableVec);
    endproperty
    a_en_set_zero: assert property (p_en_set_zero)
        else $error("zero write moved the enables");

    // Disabled slot never shows a masked bit, even when pending
    property p_suppress;
        (clkEn && !enableVec[1] && !setEnVec[1]) |=> !maskedVec[1] && userCmdIrq == maskedVec[0];
    endproperty
    a_suppress: assert property (p_suppress)
        else $error("disabled slot 1 shows masked");

    // Enable-clear write of one disables the slot
    property p_en_clr;
        (clkEn && regWr && regAddr == `OFS_ENABLE_CLEAR && regWrData[1])
            |=> !enableVec[1] ##1 (enableVec[1] == $past(setEnVec[1]) ||
                !$past(clkEn));
    endproperty
    a_en_clr: assert property (p_en_clr)
        else $error("enable clear failed");

    // Enable-clear write of zeros changes nothing
    property p_en_clr_zero;
        (clkEn && regWr && regAddr == `OFS_ENABLE_CLEAR
            && regWrData[1:0] == 2'h0) |=> $stable(enableVec);
    endproperty
    a_en_clr_zero: assert property (p_en_clr_zero)
        else $error("zero clear moved the enables");

    // Set and clear read back the one shared vector
    property p_shared_vec;
        (clkEn && regRd && (regAddr == `OFS_ENABLE_SET ||
            regAddr == `OFS_ENABLE_CLEAR)) |=>
            regRdData[1:0] == $past(enableVec) && regRdData[31:2] == 30'h0;
    endproperty
    a_shared_vec: assert property (p_shared_vec)
        else $error("enable readback mismatch");

    // Completion sets the raw flag at the next edge
    property p_raw_set;
        (clkEn && slotDone[1]) |=> rawVec[1];
    endproperty
    a_raw_set: assert property (p_raw_set)
        else $error("completion did not set raw flag");

    // Enabled completion raises the request one edge later
    property p_irq_follow;
        (clkEn && slotDone[0] && enableVec[0] && !clrEnVec[0]) |=> userCmdIrq;
    endproperty
    a_irq_follow: assert property (p_irq_follow)
        else $error("request missing after completion");

    // Request stands exactly while a masked bit is set
    property p_irq_or;
        userCmdIrq == (maskedVec[0] || maskedVec[1]);
    endproperty
    a_irq_or: assert property (p_irq_or)
        else $error("request does not match masked bits");

    // Clock enable low freezes flags and enables
    property p_freeze;
        !clkEn |=> $stable(rawVec) && $stable(enableVec) && $stable(regRdValid);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("state moved with clock enable low");

    // Read data only in the cycle after a read strobe
    property p_rd_window;
        (clkEn && !regRd) |=> regRdData == 32'h0000_0000 && !regRdValid;
    endproperty
    a_rd_window: assert property (p_rd_window)
        else $error("read data outside its cycle");

    // Masked bit 1 rises only from completion or enable
    property p_masked_cause_1;
        $rose(maskedVec[1]) |->
            ($past(slotDone[1]) && enableVec[1]) ||
            ($past(setEnVec[1]) && rawVec[1]);
    endproperty
    a_masked_cause_1: assert property (p_masked_cause_1)
        else $error("masked bit 1 rose without cause");

    // Masked read of bit 0 is pending and enabled
    property p_masked_read_0;
        (clkEn && regRd && regAddr == `OFS_MASKED_STATUS) |=>
            regRdData[0] == ($past(rawVec[0]) && $past(enableVec[0]));
    endproperty
    a_masked_read_0: assert property (p_masked_read_0)
        else $error("masked bit 0 read mismatch");

    // Writing one to masked bit 0 clears slot 0
    property p_w1c_clear_0;
        (clkEn && regWr && regAddr == `OFS_MASKED_STATUS
            && regWrData[0] && !slotDone[0]) |=> !rawVec[0];
    endproperty
    a_w1c_clear_0: assert property (p_w1c_clear_0)
        else $error("write one did not clear slot 0");

    // Raw status offset clears the same flags
    property p_raw_w1c;
        (clkEn && regWr && regAddr == `OFS_RAW_STATUS
            && regWrData[0] && !slotDone[0]) |=> !rawVec[0];
    endproperty
    a_raw_w1c: assert property (p_raw_w1c)
        else $error("raw write one did not clear slot 0");

    // Clearing both pending bits drops the request
    property p_irq_drop;
        (clkEn && regWr && regAddr == `OFS_MASKED_STATUS
            && regWrData[1:0] == 2'h3 && slotDone == 2'h0) |=> !userCmdIrq;
    endproperty
    a_irq_drop: assert property (p_irq_drop)
        else $error("request stayed after clearing");

    // Enable-set write of one enables slot 1
    property p_en_set_1;
        (clkEn && regWr && regAddr == `OFS_ENABLE_SET && regWrData[1])
            |=> enableVec[1];
    endproperty
    a_en_set_1: assert property (p_en_set_1)
        else $error("enable set of slot 1 failed");

    // Enable-clear write of one disables slot 0
    property p_en_clr_0;
        (clkEn && regWr && regAddr == `OFS_ENABLE_CLEAR && regWrData[0])
            |=> !enableVec[0];
    endproperty
    a_en_clr_0: assert property (p_en_clr_0)
        else $error("enable clear of slot 0 failed");

    // Disabled slot 0 reads back zero in the masked view
    property p_suppress_0;
        (clkEn && regRd && regAddr == `OFS_MASKED_STATUS && !enableVec[0])
            |=> !regRdData[0];
    endproperty
    a_suppress_0: assert property (p_suppress_0)
        else $error("disabled slot 0 reads masked");

    // Completion sets raw flag 0 at the next edge
    property p_raw_set_0;
        (clkEn && slotDone[0]) |=> rawVec[0];
    endproperty
    a_raw_set_0: assert property (p_raw_set_0)
        else $error("completion did not set raw flag 0");

    // Raw read shows the flags with reserved bits zero
    property p_raw_read;
        (clkEn && regRd && regAddr == `OFS_RAW_STATUS) |=>
            regRdData == {30'h0, $past(rawVec)};
    endproperty
    a_raw_read: assert property (p_raw_read)
        else $error("raw status read mismatch");

    // Unmapped address reads zero but still answers
    property p_unmapped_read;
        (clkEn && regRd && regAddr > `OFS_ENABLE_CLEAR) |=>
            regRdData == 32'h0000_0000 && regRdValid;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped read not zero");

    // Every taken read answers in the next cycle
    property p_rd_valid;
        (clkEn && regRd) |=> regRdValid;
    endproperty
    a_rd_valid: assert property (p_rd_valid)
        else $error("read not answered");

    // Enable bit 0 moves only through the set and clear strobes
    property p_en_hold_0;
        (clkEn && !setEnVec[0] && !clrEnVec[0]) |=> $stable(enableVec[0]);
    endproperty
    a_en_hold_0: assert property (p_en_hold_0)
        else $error("enable 0 moved without a strobe");

    // Completion of slot 1 beats a same-cycle clear
    property p_set_wins_1;
        (clkEn && slotDone[1] && clrRawVec[1]) |=> rawVec[1];
    endproperty
    a_set_wins_1: assert property (p_set_wins_1)
        else $error("completion of slot 1 lost to clear");

endmodule : mdio_cmd_done_irq_mask

`default_nettype wire

// file: design/cmd_done_irq_params.svh
// Offsets, field positions and reset values of the command-done interrupt block
`ifndef CMD_DONE_IRQ_PARAMS_SVH
`define CMD_DONE_IRQ_PARAMS_SVH

// Register byte offsets
`define OFS_RAW_STATUS 8'h00
`define OFS_MASKED_STATUS 8'h04
`define OFS_ENABLE_SET 8'h08
`define OFS_ENABLE_CLEAR 8'h0C

// Field of every register: bits 1-0, one bit per access slot
`define SLOT_FIELD_LSB 0
`define SLOT_FIELD_MSB 1
`define SLOT_COUNT 2

// Reset values
`define RAW_RESET 1'h0
`define ENABLE_RESET 1'h0
`define READ_DATA_RESET 32'h0000_0000

`endif

// file: design/cmd_done_irq_pkg.sv
// Types shared by the command-done interrupt block
`default_nettype none

package cmd_done_irq_pkg;

    // Register selected by the bus address
    typedef enum logic [2:0] {
        SEL_RAW,
        SEL_MASKED,
        SEL_SET,
        SEL_CLEAR,
        SEL_NONE
    } reg_sel_t;

    typedef logic [31:0] bus_word_t;

endpackage : cmd_done_irq_pkg

`default_nettype wire

// file: design/slot_ctl_if.sv
// Per-slot control and status bundle between the decoder and a slot flag
`timescale 1ns/1ps
`default_nettype none

interface slot_ctl_if;
    logic done;    // Slot command finished, one-cycle pulse
    logic clrRaw;  // Clear pending flag
    logic setEn;   // Turn interrupt enable on
    logic clrEn;   // Turn interrupt enable off
    logic raw;     // Pending completion flag
    logic en;      // Interrupt enable
    logic masked;  // Pending and enabled

    modport ctl (output done, clrRaw, setEn, clrEn, input raw, en, masked);
    modport flag (input done, clrRaw, setEn, clrEn, output raw, en, masked);
endinterface : slot_ctl_if

`default_nettype wire

// file: design/slot_flag.sv
// Pending flag and interrupt enable of one PHY access slot
`timescale 1ns/1ps
`default_nettype none
`include "cmd_done_irq_params.svh"

module slot_flag (
    input wire logic ref_clk,  // 125 MHz clock
    input wire logic rst,      // Async reset, active high
    input wire logic clkEn,    // Freezes state while low
    slot_ctl_if.flag bus       // Slot controls and status
);

    logic raw;
    logic en;

    // Completion sets the flag; set beats a same-cycle clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            raw <= `RAW_RESET;
        end else if (clkEn) begin
            if (bus.done) begin
                raw <= 1'h1;
            end else if (bus.clrRaw) begin
                raw <= 1'h0;
            end
        end
    end

    // Shared enable bit; set and clear come from different registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            en <= `ENABLE_RESET;
        end else if (clkEn) begin
            if (bus.setEn) begin
                en <= 1'h1;
            end else if (bus.clrEn) begin
                en <= 1'h0;
            end
        end
    end

    // Masked view gated by the enable
    assign bus.raw = raw;
    assign bus.en = en;
    assign bus.masked = raw & en;

endmodule : slot_flag

`default_nettype wire

// file: testbench/testbench.sv
// Self-checking bench for the command-done interrupt mask block
`timescale 1ns/1ps
`default_nettype none
`include "cmd_done_irq_params.svh"

module testbench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic clkEn = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0000_0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    cmd_done_irq_pkg::bus_word_t regRdData;
    logic regRdValid;
    logic [1:0] slotDone = 2'h0;
    logic [1:0] enableVec;
    logic userCmdIrq;
    int err_total = 0;
    int n_tests = 0;
    int cycles = 0;

    // 125 MHz clock
    always #4 ref_clk = ~ref_clk;

    mdio_cmd_done_irq_mask uut (
        .ref_clk(ref_clk),
        .rst(rst),
        .clkEn(clkEn),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWr(regWr),
        .regRd(regRd),
        .regRdData(regRdData),
        .regRdValid(regRdValid),
        .slotDone(slotDone),
        .enableVec(enableVec),
        .userCmdIrq(userCmdIrq)
    );

    // Verdict and end of run
    task results;
        if (err_total == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    // Hang guard, far above the hundred or so cycles the scenarios need
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            results();
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One-cycle write; effect visible just after the taking edge
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
        #1;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample there
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        chk({31'h0, regRdValid}, 32'h0000_0001);
        chk(regRdData, e);
    endtask : rd

    task pulse(input logic [1:0] m);
        @(posedge ref_clk);
        slotDone <= m;
        @(posedge ref_clk);
        slotDone <= 2'h0;
        #1;
    endtask : pulse

    task outs(input logic [1:0] en, input logic irq);
        chk({30'h0, enableVec}, {30'h0, en});
        chk({31'h0, userCmdIrq}, {31'h0, irq});
    endtask : outs

    // Everything idle after reset, unmapped address reads zero
    task t_reset;
        outs(2'h0, 1'b0);
        rd(`OFS_RAW_STATUS, 32'h0000_0000);
        rd(`OFS_MASKED_STATUS, 32'h0000_0000);
        rd(`OFS_ENABLE_SET, 32'h0000_0000);
        rd(8'h10, 32'h0000_0000);
    endtask : t_reset

    // Completion with enables off stays hidden
    task t_suppress;
        pulse(2'h1);
        rd(`OFS_RAW_STATUS, 32'h0000_0001);
        rd(`OFS_MASKED_STATUS, 32'h0000_0000);
        outs(2'h0, 1'b0);
        pulse(2'h2);
        rd(`OFS_RAW_STATUS, 32'h0000_0003);
    endtask : t_suppress

    task t_enable;
        wr(`OFS_ENABLE_SET, 32'h0000_0000);
        outs(2'h0, 1'b0);
        wr(`OFS_ENABLE_SET, 32'h0000_0001);
        outs(2'h1, 1'b1);
        rd(`OFS_MASKED_STATUS, 32'h0000_0001);
        wr(`OFS_ENABLE_SET, 32'h0000_0002);
        rd(`OFS_ENABLE_CLEAR, 32'h0000_0003);
        rd(`OFS_MASKED_STATUS, 32'h0000_0003);
    endtask : t_enable

    task t_clear_pending;
        wr(`OFS_MASKED_STATUS, 32'h0000_0000);
        rd(`OFS_MASKED_STATUS, 32'h0000_0003);
        wr(`OFS_MASKED_STATUS, 32'h0000_0001);
        rd(`OFS_MASKED_STATUS, 32'h0000_0002);
        outs(2'h3, 1'b1);
        wr(`OFS_MASKED_STATUS, 32'h0000_0002);
        outs(2'h3, 1'b0);
        rd(`OFS_RAW_STATUS, 32'h0000_0000);
    endtask : t_clear_pending

    // Disabling hides the pending bit, re-enabling brings it back
    task t_disable;
        pulse(2'h3);
        wr(`OFS_ENABLE_CLEAR, 32'h0000_0000);
        outs(2'h3, 1'b1);
        wr(`OFS_ENABLE_CLEAR, 32'h0000_0001);
        outs(2'h2, 1'b1);
        rd(`OFS_ENABLE_SET, 32'h0000_0002);
        rd(`OFS_MASKED_STATUS, 32'h0000_0002);
        wr(`OFS_ENABLE_CLEAR, 32'h0000_0002);
        outs(2'h0, 1'b0);
        rd(`OFS_RAW_STATUS, 32'h0000_0003);
        wr(`OFS_ENABLE_SET, 32'h0000_0001);
        outs(2'h1, 1'b1);
        wr(`OFS_MASKED_STATUS, 32'h0000_0003);
        outs(2'h1, 1'b0);
    endtask : t_disable

    // Completion in the same cycle as its clear must not be lost
    task t_collide;
        @(posedge ref_clk);
        slotDone <= 2'h1;
        regWr <= 1'b1;
        regAddr <= `OFS_MASKED_STATUS;
        regWrData <= 32'h0000_0001;
        @(posedge ref_clk);
        slotDone <= 2'h0;
        regWr <= 1'b0;
        #1;
        rd(`OFS_RAW_STATUS, 32'h0000_0001);
    endtask : t_collide

    // Strobes and completions while frozen are ignored
    task t_freeze;
        @(posedge ref_clk);
        clkEn <= 1'b0;
        wr(`OFS_ENABLE_SET, 32'h0000_0002);
        pulse(2'h2);
        outs(2'h1, 1'b1);
        @(posedge ref_clk);
        clkEn <= 1'b1;
        rd(`OFS_RAW_STATUS, 32'h0000_0001);
    endtask : t_freeze

    // Raw offset clears too; unmapped writes are ignored
    task t_raw_clear;
        wr(8'h10, 32'h0000_0003);
        outs(2'h1, 1'b1);
        wr(`OFS_RAW_STATUS, 32'h0000_0000);
        rd(`OFS_RAW_STATUS, 32'h0000_0001);
        wr(`OFS_RAW_STATUS, 32'h0000_0001);
        outs(2'h1, 1'b0);
        rd(`OFS_RAW_STATUS, 32'h0000_0000);
    endtask : t_raw_clear

    // Reset in mid-run drops flags, enables and request
    task t_rerun_reset;
        wr(`OFS_ENABLE_SET, 32'h0000_0003);
        pulse(2'h3);
        outs(2'h3, 1'b1);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        outs(2'h0, 1'b0);
        rd(`OFS_RAW_STATUS, 32'h0000_0000);
    endtask : t_rerun_reset

    // Reset for 8 cycles, then the scenarios in order
    initial begin
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        t_reset();
        t_suppress();
        t_enable();
        t_clear_pending();
        t_disable();
        t_collide();
        t_freeze();
        t_raw_clear();
        t_rerun_reset();
        results();
    end
endmodule : testbench

`default_nettype wire
